// ==== pkg/ffc_pkg.sv ====
// constants for the fan fault, count and target register block
package ffc_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_MODE      = 8'h96;
    localparam logic [7:0] IDX_SAVED     = 8'h9E;
    localparam logic [7:0] IDX_FTIME     = 8'h9F;
    localparam logic [7:0] IDX_CNT_HI    = 8'hA0;
    localparam logic [7:0] IDX_CNT_LO    = 8'hA1;
    localparam logic [7:0] IDX_TGT_HI    = 8'hA2;
    localparam logic [7:0] IDX_TGT_LO    = 8'hA3;
    localparam logic [7:0] IDX_FULL_HI   = 8'hA4;
    localparam logic [7:0] IDX_FULL_LO   = 8'hA5;
    localparam logic [7:0] IDX_STATUS    = 8'hB0;
    localparam int         ADDR_W        = 10;
    // reset values
    localparam logic [3:0] FTIME_RST     = 4'hA;
    localparam logic [7:0] CNT_HI_RST    = 8'h0F;
    localparam logic [7:0] CNT_LO_RST    = 8'hFF;
    localparam logic [7:0] TGT_HI_RST    = 8'h00;
    localparam logic [7:0] TGT_LO_RST    = 8'h01;
    localparam logic [7:0] FULL_HI_RST   = 8'h03;
    localparam logic [7:0] FULL_LO_RST   = 8'hFF;
    localparam logic [1:0] MODE_RST      = 2'h0;
    // field positions
    localparam int         MODE_DUTY_B   = 0;
    localparam int         MODE_MANUAL_B = 1;
    localparam int         FULLSEL_B     = 4;
    localparam int         STAT_FAULT_B  = 0;
    // duty codes
    localparam logic [7:0] DUTY_MAX      = 8'hFF;
    localparam logic [7:0] DUTY_FULL     = 8'hFF;
    localparam logic [7:0] DUTY_40PCT    = 8'h66;
    // timing
    localparam longint     FAULT_UNIT_NS = 1000000000;
    localparam longint     CLK_PERIOD_NS = 4;
    localparam int         CYC_PER_SEC   = int'(FAULT_UNIT_NS / CLK_PERIOD_NS);
    localparam logic [1:0] STRAP_SETTLE  = 2'h2;
    // bus responses
    localparam logic [1:0] RESP_OKAY     = 2'h0;
    localparam logic [1:0] RESP_SLVERR   = 2'h2;
endpackage

// ==== verilog/ffc_fan_regs.sv ====
// fan fault timer, latched fan counts, target and power-on duty, behind an axi4-lite slave
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/100ps
module ffc_fan_regs #(
    parameter int CYC_PER_SEC = ffc_pkg::CYC_PER_SEC
) (
    input  wire logic        aclk,             // 250 MHz clock
    input  wire logic        aresetn,          // synchronous reset, active low
    input  wire logic [9:0]  s_axi_awaddr,     // write address
    input  wire logic        s_axi_awvalid,    // write address valid
    output logic             s_axi_awready,    // write address ready
    input  wire logic [31:0] s_axi_wdata,      // write data
    input  wire logic [3:0]  s_axi_wstrb,      // write strobes
    input  wire logic        s_axi_wvalid,     // write data valid
    output logic             s_axi_wready,     // write data ready
    output logic [1:0]       s_axi_bresp,      // write response
    output logic             s_axi_bvalid,     // write response valid
    input  wire logic        s_axi_bready,     // write response ready
    input  wire logic [9:0]  s_axi_araddr,     // read address
    input  wire logic        s_axi_arvalid,    // read address valid
    output logic             s_axi_arready,    // read address ready
    output logic [31:0]      s_axi_rdata,      // read data
    output logic [1:0]       s_axi_rresp,      // read response
    output logic             s_axi_rvalid,     // read data valid
    input  wire logic        s_axi_rready,     // read data ready
    input  wire logic        duty_strap_pin,   // power-on duty choice strap
    input  wire logic        saved_duty_valid, // saved duty byte was programmed
    input  wire logic [7:0]  saved_duty_byte,  // saved power-on duty
    input  wire logic [15:0] fan_count_in,     // measured tach count
    input  wire logic [7:0]  pwm_duty_in,      // present drive duty
    input  wire logic [7:0]  start_duty_in,    // minimum start-up duty
    input  wire logic        fan_stopped_in,   // fan reported stopped
    input  wire logic        auto_we,          // auto loop updates target
    input  wire logic [15:0] auto_target_in,   // auto loop target value
    output logic [1:0]       fan_mode,         // mode bits
    output logic [15:0]      fan_target,       // expected count or duty
    output logic [15:0]      fan_fullspeed,    // full-speed count
    output logic [7:0]       poweron_duty,     // power-on duty
    output logic             poweron_valid,    // power-on duty loaded
    output logic             fan_fault_evt     // one-cycle fault event
);
    // bus state
    logic        awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
    logic        aw_held_r, w_held_r;
    logic [7:0]  aw_idx_r;
    logic [7:0]  wdat_r;
    logic        wlane_r;
    logic [31:0] rdata_r;
    logic [1:0]  rresp_r, bresp_r;
    // block state
    logic [1:0]  mode_r;
    logic [3:0]  ftime_r;
    logic        fullsel_r;
    logic [7:0]  tgt_hi_r, tgt_lo_r, full_hi_r, full_lo_r;
    logic [7:0]  cnt_lo_frz_r, full_lo_frz_r;
    logic        fault_flag_r, fault_evt_r;
    logic [31:0] pre_r;
    logic [4:0]  sec_r;
    logic        strap_s1_r, strap_s2_r;
    logic [1:0]  settle_r;
    logic        pon_valid_r;
    logic [7:0]  pon_duty_r;

    // write channel
    wire aw_take   = s_axi_awvalid & awready_r;
    wire w_take    = s_axi_wvalid & wready_r;
    wire wr_do     = aw_held_r & w_held_r & ~bvalid_r;
    wire aw_hnxt   = (aw_held_r | aw_take) & ~wr_do;
    wire w_hnxt    = (w_held_r | w_take) & ~wr_do;
    wire bv_nxt    = wr_do | (bvalid_r & ~s_axi_bready);
    wire wr_en     = wr_do & wlane_r;
    wire wr_mode   = wr_en && aw_idx_r == ffc_pkg::IDX_MODE;
    wire wr_ftime  = wr_en && aw_idx_r == ffc_pkg::IDX_FTIME;
    wire wr_tgt_hi = wr_en && aw_idx_r == ffc_pkg::IDX_TGT_HI;
    wire wr_tgt_lo = wr_en && aw_idx_r == ffc_pkg::IDX_TGT_LO;
    wire wr_full_h = wr_en && aw_idx_r == ffc_pkg::IDX_FULL_HI;
    wire wr_full_l = wr_en && aw_idx_r == ffc_pkg::IDX_FULL_LO;
    wire wr_stat   = wr_en && aw_idx_r == ffc_pkg::IDX_STATUS;
    wire wr_known  = aw_idx_r == ffc_pkg::IDX_MODE || aw_idx_r == ffc_pkg::IDX_SAVED
                  || aw_idx_r == ffc_pkg::IDX_FTIME || aw_idx_r == ffc_pkg::IDX_STATUS
                  || (aw_idx_r >= ffc_pkg::IDX_CNT_HI && aw_idx_r <= ffc_pkg::IDX_FULL_LO);

    // read channel
    wire        ar_take  = s_axi_arvalid & arready_r;
    wire        rv_nxt   = ar_take | (rvalid_r & ~s_axi_rready);
    wire [7:0]  ar_idx   = s_axi_araddr[9:2];
    wire        duty_md  = mode_r[ffc_pkg::MODE_DUTY_B];
    wire        auto_md  = ~mode_r[ffc_pkg::MODE_MANUAL_B];
    wire        rd_cnt_h = ar_take && ar_idx == ffc_pkg::IDX_CNT_HI;
    wire        rd_full_h = ar_take && ar_idx == ffc_pkg::IDX_FULL_HI;
    wire [7:0]  tgt_hi_vis = duty_md ? 8'h00 : tgt_hi_r;
    wire [7:0]  ftime_vis  = {3'h0, fullsel_r, ftime_r};
    wire [7:0]  stat_vis   = {7'h00, fault_flag_r};
    wire        rd_hit   = ar_idx == ffc_pkg::IDX_MODE || ar_idx == ffc_pkg::IDX_SAVED
                        || ar_idx == ffc_pkg::IDX_FTIME || ar_idx == ffc_pkg::IDX_STATUS
                        || (ar_idx >= ffc_pkg::IDX_CNT_HI && ar_idx <= ffc_pkg::IDX_FULL_LO);
    wire [7:0]  rd_byte  =
        ar_idx == ffc_pkg::IDX_MODE    ? {6'h00, mode_r} :
        ar_idx == ffc_pkg::IDX_SAVED   ? pon_duty_r :
        ar_idx == ffc_pkg::IDX_FTIME   ? ftime_vis :
        ar_idx == ffc_pkg::IDX_CNT_HI  ? fan_count_in[15:8] :
        ar_idx == ffc_pkg::IDX_CNT_LO  ? cnt_lo_frz_r :
        ar_idx == ffc_pkg::IDX_TGT_HI  ? tgt_hi_vis :
        ar_idx == ffc_pkg::IDX_TGT_LO  ? tgt_lo_r :
        ar_idx == ffc_pkg::IDX_FULL_HI ? full_hi_r :
        ar_idx == ffc_pkg::IDX_FULL_LO ? full_lo_frz_r :
        ar_idx == ffc_pkg::IDX_STATUS  ? stat_vis : 8'h00;

    // fault detection
    wire        short_spd = (pwm_duty_in == ffc_pkg::DUTY_MAX) & ~duty_md
                          & (fan_count_in > {tgt_hi_r, tgt_lo_r});
    wire        stall     = fan_stopped_in & (pwm_duty_in > start_duty_in);
    wire        fault_c   = short_spd | stall;
    wire        sec_tick  = pre_r == 32'(CYC_PER_SEC - 1);
    wire        time_up   = sec_tick && sec_r == {1'b0, ftime_r};
    wire        fault_now = fault_c & time_up;
    wire        clr_fault = wr_stat & wdat_r[ffc_pkg::STAT_FAULT_B];

    // power-on duty
    wire        settled   = settle_r == ffc_pkg::STRAP_SETTLE;
    wire [7:0]  strap_dty = strap_s2_r ? ffc_pkg::DUTY_40PCT : ffc_pkg::DUTY_FULL;

    // auto target update
    wire        hw_upd    = auto_md & auto_we;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_r <= 1'b0;
            wready_r  <= 1'b0;
            bvalid_r  <= 1'b0;
            arready_r <= 1'b0;
            rvalid_r  <= 1'b0;
            aw_held_r <= 1'b0;
            w_held_r  <= 1'b0;
            aw_idx_r  <= 8'h00;
            wdat_r    <= 8'h00;
            wlane_r   <= 1'b0;
            rdata_r   <= 32'h00000000;
            rresp_r   <= ffc_pkg::RESP_OKAY;
            bresp_r   <= ffc_pkg::RESP_OKAY;
        end else begin
            aw_held_r <= aw_hnxt;
            w_held_r  <= w_hnxt;
            awready_r <= ~aw_hnxt & ~bv_nxt;
            wready_r  <= ~w_hnxt & ~bv_nxt;
            bvalid_r  <= bv_nxt;
            arready_r <= ~rv_nxt;
            rvalid_r  <= rv_nxt;
            if (aw_take) begin
                aw_idx_r <= s_axi_awaddr[9:2];
            end
            if (w_take) begin
                wdat_r  <= s_axi_wdata[7:0];
                wlane_r <= s_axi_wstrb[0];
            end
            if (wr_do) begin
                bresp_r <= wr_known ? ffc_pkg::RESP_OKAY : ffc_pkg::RESP_SLVERR;
            end
            if (ar_take) begin
                rdata_r <= {24'h000000, rd_byte};
                rresp_r <= rd_hit ? ffc_pkg::RESP_OKAY : ffc_pkg::RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_r        <= ffc_pkg::MODE_RST;
            ftime_r       <= ffc_pkg::FTIME_RST;
            tgt_hi_r      <= ffc_pkg::TGT_HI_RST;
            tgt_lo_r      <= ffc_pkg::TGT_LO_RST;
            full_hi_r     <= ffc_pkg::FULL_HI_RST;
            full_lo_r     <= ffc_pkg::FULL_LO_RST;
            cnt_lo_frz_r  <= ffc_pkg::CNT_LO_RST;
            full_lo_frz_r <= ffc_pkg::FULL_LO_RST;
        end else begin
            if (wr_mode) begin
                mode_r <= wdat_r[1:0];
            end
            if (wr_ftime) begin
                ftime_r <= wdat_r[3:0];
            end
            if (hw_upd) begin
                tgt_hi_r <= auto_target_in[15:8];
                tgt_lo_r <= auto_target_in[7:0];
            end else begin
                if (wr_tgt_hi && !duty_md) begin
                    tgt_hi_r <= wdat_r;
                end
                if (wr_tgt_lo && !auto_md) begin
                    tgt_lo_r <= wdat_r;
                end
            end
            if (wr_full_h) begin
                full_hi_r <= wdat_r;
            end
            if (wr_full_l) begin
                full_lo_r <= wdat_r;
            end
            if (rd_cnt_h) begin
                cnt_lo_frz_r <= fan_count_in[7:0];
            end
            if (rd_full_h) begin
                full_lo_frz_r <= full_lo_r;
            end
        end
    end

    // fault timer: prescaler to seconds, restarts when the condition drops
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pre_r        <= 32'h00000000;
            sec_r        <= 5'h00;
            fault_evt_r  <= 1'b0;
            fault_flag_r <= 1'b0;
        end else begin
            if (!fault_c || time_up) begin
                pre_r <= 32'h00000000;
                sec_r <= 5'h00;
            end else if (sec_tick) begin
                pre_r <= 32'h00000000;
                sec_r <= sec_r + 5'h01;
            end else begin
                pre_r <= pre_r + 32'h00000001;
            end
            fault_evt_r <= fault_now;
            if (fault_now) begin
                fault_flag_r <= 1'b1;
            end else if (clr_fault) begin
                fault_flag_r <= 1'b0;
            end
        end
    end

    // strap capture after reset release
    always_ff @(posedge aclk) begin
        strap_s1_r <= duty_strap_pin;
        strap_s2_r <= strap_s1_r;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            settle_r    <= 2'h0;
            fullsel_r   <= 1'b1;
            pon_valid_r <= 1'b0;
            pon_duty_r  <= ffc_pkg::DUTY_FULL;
        end else begin
            if (!settled) begin
                settle_r <= settle_r + 2'h1;
            end
            if (settled && !pon_valid_r) begin
                pon_valid_r <= 1'b1;
                fullsel_r   <= strap_s2_r;
                pon_duty_r  <= saved_duty_valid ? saved_duty_byte : strap_dty;
            end else if (wr_ftime) begin
                fullsel_r <= wdat_r[ffc_pkg::FULLSEL_B];
            end
        end
    end

    assign s_axi_awready = awready_r;
    assign s_axi_wready  = wready_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;
    assign fan_mode      = mode_r;
    assign fan_target    = {tgt_hi_r, tgt_lo_r};
    assign fan_fullspeed = {full_hi_r, full_lo_r};
    assign poweron_duty  = pon_duty_r;
    assign poweron_valid = pon_valid_r;
    assign fan_fault_evt = fault_evt_r;
endmodule

// ==== verification/ffc_fan_regs_sva.sv ====
// port assertions for the fan fault, count and target block
`timescale 1ns/100ps
module ffc_fan_regs_sva #(
    parameter int CYC_PER_SEC = 10
) (
    input logic        aclk,             // clock
    input logic        aresetn,          // reset
    input logic        s_axi_bvalid,     // b valid
    input logic        s_axi_bready,     // b ready
    input logic        s_axi_rvalid,     // r valid
    input logic        s_axi_rready,     // r ready
    input logic        s_axi_arready,    // ar ready
    input logic [31:0] s_axi_rdata,      // read data
    input logic        duty_strap_pin,   // strap
    input logic        saved_duty_valid, // saved byte valid
    input logic [7:0]  saved_duty_byte,  // saved byte
    input logic [15:0] fan_count_in,     // tach count
    input logic [7:0]  pwm_duty_in,      // duty
    input logic [7:0]  start_duty_in,    // start duty
    input logic        fan_stopped_in,   // stopped
    input logic        auto_we,          // auto update
    input logic [15:0] auto_target_in,   // auto value
    input logic [1:0]  fan_mode,         // mode
    input logic [15:0] fan_target,       // target
    input logic [7:0]  poweron_duty,     // power-on duty
    input logic        poweron_valid,    // power-on loaded
    input logic        fan_fault_evt     // fault pulse
);
    logic cond;
    int   held_r;
    assign cond = (pwm_duty_in == 8'hFF && !fan_mode[0] && fan_count_in > fan_target) ||
                  (fan_stopped_in && pwm_duty_in > start_duty_in);
    // cycles the fault condition has held without a break
    always_ff @(posedge aclk) held_r <= (!aresetn || !cond) ? 0 : held_r + 1;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
    a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer not held");
    a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("arready with rvalid");
    a_evt_pulse: assert property (fan_fault_evt |=> !fan_fault_evt) else $error("fault pulse too long");
    a_fault_hold: assert property (fan_fault_evt |-> held_r >= CYC_PER_SEC) else $error("fault too early");
    a_auto_load: assert property (auto_we && !fan_mode[1] |=> fan_target == $past(auto_target_in))
        else $error("auto target not loaded");
    a_pon_duty: assert property ($rose(poweron_valid) |-> poweron_duty == (saved_duty_valid ? saved_duty_byte :
        duty_strap_pin ? ffc_pkg::DUTY_40PCT : ffc_pkg::DUTY_FULL)) else $error("wrong power-on duty");
    a_pon_stay: assert property (poweron_valid |=> poweron_valid) else $error("power-on flag fell");
    c_fault: cover property (fan_fault_evt);
    c_auto: cover property (auto_we && !fan_mode[1]);
    c_pon: cover property ($rose(poweron_valid));
endmodule
bind ffc_fan_regs ffc_fan_regs_sva #(.CYC_PER_SEC(CYC_PER_SEC)) u_sva (.*);

// ==== verification/ffc_fan_model.sv ====
// behavioural fan: tach count follows drive duty, stalls on command
`timescale 1ns/100ps
module ffc_fan_model (
    input  wire logic        aclk,               // clock
    input  wire logic [7:0]  pwm_duty,           // drive duty
    input  wire logic        stall,              // rotor stall
    output logic      [15:0] fan_count = 16'hFFFF, // higher is slower
    output logic             fan_stopped = 1'b0  // rotor stopped
);
    always @(posedge aclk) begin
        fan_count <= stall ? 16'hFFFF : 16'h0100 + {8'h00, ~pwm_duty};
        fan_stopped <= stall;
    end
endmodule

// ==== verification/ffc_fan_regs_bench.sv ====
// register-level bench for the fan fault, count and target block
`timescale 1ns/100ps
module ffc_fan_regs_bench;
    localparam int CPS = 10;
    logic        aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic        s_axi_arvalid = 0, s_axi_rready = 0, duty_strap_pin = 1, saved_duty_valid = 0, auto_we = 0;
    logic        stall = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        fan_stopped_in, poweron_valid, fan_fault_evt;
    logic [9:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic [1:0]  s_axi_bresp, s_axi_rresp, fan_mode;
    logic [7:0]  saved_duty_byte = 0, pwm_duty_in = 8'h40, start_duty_in = 8'h20, poweron_duty;
    logic [15:0] fan_count_in, auto_target_in = 0, fan_target, fan_fullspeed;
    int          err_count = 0, checks_done = 0, cyc = 0, n;
    ffc_fan_regs #(.CYC_PER_SEC(CPS)) DUT (.*);
    ffc_fan_model u_fan (.aclk(aclk), .pwm_duty(pwm_duty_in), .stall(stall), .fan_count(fan_count_in),
                         .fan_stopped(fan_stopped_in));
    always #2 aclk = ~aclk;
    task automatic close_out();
        $display("errors %0d checks %0d", err_count, checks_done);
        if (err_count == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            close_out();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] i, input logic [7:0] d, input logic [1:0] er = 2'h0);
        logic a, w;
        a = 1;
        w = 1;
        s_axi_awaddr <= {i, 2'h0};
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        while (a || w) begin
            @(posedge aclk);
            if (a && s_axi_awready) begin a = 0; s_axi_awvalid <= 0; end
            if (w && s_axi_wready) begin w = 0; s_axi_wvalid <= 0; end
        end
        do @(posedge aclk); while (!s_axi_bvalid);
        s_axi_bready <= 0;
        chk(s_axi_bresp, er);
        @(posedge aclk);
    endtask
    task automatic rd(input logic [7:0] i, input logic [7:0] exp, input logic [1:0] er = 2'h0);
        s_axi_araddr <= {i, 2'h0};
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 0;
        while (!s_axi_rvalid) @(posedge aclk);
        s_axi_rready <= 0;
        chk(s_axi_rdata, {24'h0, exp});
        chk(s_axi_rresp, er);
        @(posedge aclk);
    endtask
    task automatic rst(input logic s, input logic v, input logic [7:0] b);
        aresetn <= 0;
        duty_strap_pin <= s;
        saved_duty_valid <= v;
        saved_duty_byte <= b;
        repeat (20) @(posedge aclk);
        aresetn <= 1;
        repeat (5) @(posedge aclk);
    endtask
    // cycles until the next fault pulse, capped at 60
    task automatic wait_evt();
        n = 0;
        while (fan_fault_evt !== 1'b1 && n < 60) begin
            @(posedge aclk);
            n++;
        end
    endtask
    initial begin
        rst(1, 0, 8'h00);
        chk(poweron_duty, 8'h66);
        chk(poweron_valid, 1'b1);
        rd(8'h9E, 8'h66);
        rd(8'h9F, 8'h1A);
        rd(8'hA2, 8'h00);
        rd(8'hA3, 8'h01);
        rd(8'hA4, 8'h03);
        rd(8'hA5, 8'hFF);
        rd(8'h00, 8'h00, 2'h2);
        wr(8'h00, 8'h55, 2'h2);
        rd(8'hA0, 8'h01);
        pwm_duty_in <= 8'h80;
        repeat (3) @(posedge aclk);
        rd(8'hA1, 8'hBF);
        rd(8'hA0, 8'h01);
        rd(8'hA1, 8'h7F);
        wr(8'hA4, 8'h12);
        wr(8'hA5, 8'h34);
        rd(8'hA4, 8'h12);
        wr(8'hA5, 8'h56);
        rd(8'hA5, 8'h34);
        rd(8'hA4, 8'h12);
        rd(8'hA5, 8'h56);
        chk(fan_fullspeed, 16'h1256);
        s_axi_wstrb <= 4'hE;
        wr(8'hA4, 8'h99);
        s_axi_wstrb <= 4'hF;
        rd(8'hA4, 8'h12);
        wr(8'hA3, 8'h77);
        rd(8'hA3, 8'h01);
        auto_target_in <= 16'h2345;
        auto_we <= 1;
        @(posedge aclk);
        auto_we <= 0;
        rd(8'hA2, 8'h23);
        rd(8'hA3, 8'h45);
        chk(fan_target, 16'h2345);
        wr(8'h96, 8'h02);
        wr(8'hA3, 8'h88);
        rd(8'hA3, 8'h88);
        wr(8'h96, 8'h03);
        chk(fan_mode, 2'h3);
        wr(8'hA2, 8'h55);
        rd(8'hA2, 8'h00);
        wr(8'h96, 8'h02);
        wr(8'hA2, 8'h00);
        wr(8'hA3, 8'h10);
        wr(8'h9F, 8'h01);
        rd(8'h9F, 8'h01);
        // interrupted condition first, then an unbroken two seconds
        pwm_duty_in <= 8'hFF;
        repeat (12) @(posedge aclk);
        pwm_duty_in <= 8'h80;
        repeat (3) @(posedge aclk);
        pwm_duty_in <= 8'hFF;
        wait_evt();
        chk(n >= 2 * CPS && n <= 2 * CPS + 5, 1);
        pwm_duty_in <= 8'h80;
        rd(8'hB0, 8'h01);
        wr(8'hB0, 8'h01);
        rd(8'hB0, 8'h00);
        stall <= 1;
        wait_evt();
        chk(n >= 2 * CPS && n <= 2 * CPS + 5, 1);
        pwm_duty_in <= 8'h10;
        @(posedge aclk);
        wait_evt();
        chk(n, 60);
        stall <= 0;
        rst(0, 0, 8'h00);
        rd(8'h9E, 8'hFF);
        rd(8'h9F, 8'h0A);
        rst(0, 1, 8'h5A);
        chk(poweron_duty, 8'h5A);
        close_out();
    end
endmodule
